// ===== bench/ulpr_bank_assertions.sv
// Purpose : port checks for the list pointer register bank
// Assumes : zero wait states, full system byte addresses
// Notes   : bound to ulpr_bank from the bench top
`timescale 1ns/1ps

module ulpr_bank_checker (
  // clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       clk_en,
  // bus
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  // list engine
  input wire ulpr_pkg::ulpr_engine_req_t engine_req,
  input wire ulpr_pkg::ulpr_pointers_t   pointers
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken;
  assign taken = hsel && hready && clk_en && (htrans == ulpr_pkg::HTRANS_NONSEQ);
  sequence s_wr(a);
    taken && hwrite && (haddr == a);
  endsequence
  sequence s_rd(a);
    taken && !hwrite && (haddr == a);
  endsequence

  AST_BASE_LOW_ZERO: assert property (pointers.comm_area_base_field[7:0] == 8'h00)
    else $error("base low bits not zero");
  AST_DESC_LOW_ZERO: assert property ((pointers.periodic_current_pointer[3:0] == 4'h0)
    && (pointers.control_head_pointer[3:0] == 4'h0)) else $error("pointer low bits not zero");
  AST_BASE_WRITE: assert property (s_wr(ulpr_pkg::ADDR_COMM_AREA_BASE) ##1 clk_en
    |=> pointers.comm_area_base_field == ($past(hwdata) & 32'hFFFF_FF00))
    else $error("base write not stored");
  AST_HEAD_WRITE: assert property (s_wr(ulpr_pkg::ADDR_CONTROL_LIST_HEAD)
    ##1 (clk_en && !engine_req.head_init_load)
    |=> pointers.control_head_pointer == ($past(hwdata) & 32'hFFFF_FFF0))
    else $error("head write not stored");
  AST_PERIODIC_RO: assert property (s_wr(ulpr_pkg::ADDR_PERIODIC_CURRENT)
    ##1 !engine_req.periodic_update |=> $stable(pointers.periodic_current_pointer))
    else $error("periodic pointer took a bus write");
  AST_PERIODIC_UPD: assert property (clk_en && engine_req.periodic_update
    |=> pointers.periodic_current_pointer == ($past(engine_req.periodic_value) & 32'hFFFF_FFF0))
    else $error("periodic update lost");
  AST_HEAD_INIT: assert property (clk_en && engine_req.head_init_load
    |=> pointers.control_head_pointer == ($past(engine_req.head_init_value) & 32'hFFFF_FFF0))
    else $error("head init load lost");
  AST_BASE_READ: assert property (s_rd(ulpr_pkg::ADDR_COMM_AREA_BASE)
    |=> hrdata == pointers.comm_area_base_field) else $error("base read wrong");
  AST_PERIODIC_READ: assert property (s_rd(ulpr_pkg::ADDR_PERIODIC_CURRENT)
    && !engine_req.periodic_update |=> hrdata == pointers.periodic_current_pointer)
    else $error("periodic read wrong");
endmodule

// ===== bench/ulpr_bank_tb.sv
// Purpose : register-level test of the list pointer bank
// Assumes : single slave, hready tied to hreadyout
// Notes   : addresses are full system byte addresses
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module ulpr_bank_tb;
  logic                       hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0]                haddr, hwdata, hrdata, rd;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  wire logic                  hready;
  ulpr_pkg::ulpr_engine_req_t engine_req;
  ulpr_pkg::ulpr_pointers_t   pointers;
  int                         errors, checks_done, cycles;
  localparam logic [31:0] BASE = ulpr_pkg::ADDR_COMM_AREA_BASE;
  localparam logic [31:0] PER  = ulpr_pkg::ADDR_PERIODIC_CURRENT;
  localparam logic [31:0] HEAD = ulpr_pkg::ADDR_CONTROL_LIST_HEAD;
  localparam logic [31:0] NONE = 32'hE000_7024;
  assign hready = hreadyout;

  ulpr_bank dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .engine_req(engine_req),
    .pointers(pointers));
  ulpr_engine_model eng (.hclk(hclk), .req(engine_req));

  // ------------------------------------------------
  // bus tasks
  // ------------------------------------------------
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= ulpr_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= ulpr_pkg::HTRANS_IDLE; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string n, input logic [31:0] a, e);
    ahb_xfer(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rd)
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // hang guard, well above the roughly 42 cycles used
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0000_0000;
    htrans = ulpr_pkg::HTRANS_IDLE; hsize = 3'h2; hwdata = 32'h0000_0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("base reset", BASE, 32'h0000_0000);
    rd_chk("periodic reset", PER, 32'h0000_0000);
    rd_chk("head reset", HEAD, 32'h0000_0000);
    ahb_xfer(1'b1, BASE, 32'hFFFF_FFFF);
    rd_chk("base all ones", BASE, 32'hFFFF_FF00);
    `CHK("base field", 32'hFFFF_FF00, pointers.comm_area_base_field)
    ahb_xfer(1'b1, HEAD, 32'hFFFF_FFFF);
    rd_chk("head all ones", HEAD, 32'hFFFF_FFF0);
    ahb_xfer(1'b1, PER, 32'hFFFF_FFFF);
    `CHK("ro write resp", ulpr_pkg::HRESP_OKAY, hresp)
    `CHK("ro write ready", ulpr_pkg::HREADY_DONE, hreadyout)
    rd_chk("periodic ro", PER, 32'h0000_0000);
    eng.service_periodic(32'h1234_567F);
    rd_chk("periodic update", PER, 32'h1234_5670);
    `CHK("periodic field", 32'h1234_5670, pointers.periodic_current_pointer)
    // enable low: the engine pulse must not land
    clk_en <= 1'b0;
    eng.service_periodic(32'h0000_0AB0);
    clk_en <= 1'b1;
    rd_chk("periodic frozen", PER, 32'h1234_5670);
    ahb_xfer(1'b1, BASE, 32'h0001_23FF);
    eng.init_head(32'h0ABC_DEF7);
    rd_chk("head init", HEAD, 32'h0ABC_DEF0);
    `CHK("head field", 32'h0ABC_DEF0, pointers.control_head_pointer)
    `CHK("area base kept", 32'h0001_2300, pointers.comm_area_base_field)
    ahb_xfer(1'b1, NONE, 32'h5A5A_5A5A);
    rd_chk("unmapped", NONE, ulpr_pkg::UNMAPPED_READ);
    rd_chk("base untouched", BASE, 32'h0001_2300);
    end_sim();
  end
endmodule

bind ulpr_bank ulpr_bank_checker chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .engine_req(engine_req), .pointers(pointers));

// ===== bench/ulpr_engine_model.sv
// Purpose : list engine stand-in driving pointer updates
// Assumes : called just after a rising edge
// Notes   : one-cycle pulses, as the engine request contract asks
`timescale 1ns/1ps

module ulpr_engine_model (
  // clock
  input wire logic                  hclk,
  // requests to the bank
  output ulpr_pkg::ulpr_engine_req_t req
);
  initial req = '0;
  // descriptor serviced: publish progress
  task automatic service_periodic(input logic [31:0] v);
    req.periodic_value  <= v;
    req.periodic_update <= 1'b1;
    @(posedge hclk);
    req.periodic_update <= 1'b0;
  endtask
  // word fetched from the shared area at init
  task automatic init_head(input logic [31:0] area_word);
    req.head_init_value <= area_word;
    req.head_init_load  <= 1'b1;
    @(posedge hclk);
    req.head_init_load  <= 1'b0;
  endtask
endmodule

// ===== rtl/ulpr_bank.sv
// Purpose : memory pointer registers of a descriptor-list USB host controller
// Assumes : one clock hclk, AHB-Lite slave, list engine on the same clock
// Notes   : zero wait states; reads see a write whose data phase is in flight
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

// What this block does
// - The low eight bits of the communication-area base always read as zero.
// - The base field is bits 31:8, resets to zero, software-writable, engine-read.
// - The periodic pointer is bits 31:4, resets to zero, read-only to software.
// - The engine reads the periodic pointer and updates it after each descriptor.
// - The control head is bits 31:4, resets to zero, software-writable, engine-read.
// - At initialisation the engine loads the control head from the shared area.
// - The shared area holds control structures and the interrupt table for both.
module ulpr_bank (
  // clock, reset, enable
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       clk_en,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // list engine
  input  wire ulpr_pkg::ulpr_engine_req_t engine_req,
  output ulpr_pkg::ulpr_pointers_t        pointers
);

  // ---------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------
  ulpr_pkg::ulpr_bus_cmd_t cmd_reg;
  ulpr_pkg::ulpr_bus_cmd_t cmd_next;
  logic [31:0]             hrdata_reg;
  logic [31:0]             hrdata_next;
  logic                    hreadyout_reg;
  logic                    hreadyout_next;
  logic                    hresp_reg;
  logic                    hresp_next;

  // ---------------------------------------------------------------
  // register table
  // ---------------------------------------------------------------
  // the index is shared by the storage, the decode and the read mux
  localparam int REG_COUNT    = 3;
  localparam int IDX_W        = 2;
  localparam int IDX_COMM     = 0;
  localparam int IDX_PERIODIC = 1;
  localparam int IDX_HEAD     = 2;

  localparam logic [31:0] REG_ADDR [REG_COUNT] = '{
    ulpr_pkg::ADDR_COMM_AREA_BASE,
    ulpr_pkg::ADDR_PERIODIC_CURRENT,
    ulpr_pkg::ADDR_CONTROL_LIST_HEAD
  };

  localparam int REG_LOW_BITS [REG_COUNT] = '{
    ulpr_pkg::COMM_AREA_LOW_BITS,
    ulpr_pkg::DESCRIPTOR_LOW_BITS,
    ulpr_pkg::DESCRIPTOR_LOW_BITS
  };

  // ---------------------------------------------------------------
  // decode and per-entry signals
  // ---------------------------------------------------------------
  logic                 addr_phase;
  logic                 rd_addr_phase;
  logic                 wr_data_phase;
  logic [REG_COUNT-1:0] addr_hit;
  logic [REG_COUNT-1:0] data_hit;
  logic                 addr_known;
  logic [IDX_W-1:0]     addr_idx;
  logic [REG_COUNT-1:0] sw_we;
  logic [REG_COUNT-1:0] hw_we;
  logic [31:0]          hw_wdata       [REG_COUNT];
  logic [31:0]          reg_value      [REG_COUNT];
  logic [31:0]          reg_value_next [REG_COUNT];

  // hsize is not checked: only whole words are ever issued to this bank
  assign addr_phase    = hsel && hready && (htrans == ulpr_pkg::HTRANS_NONSEQ);
  assign rd_addr_phase = addr_phase && !hwrite;
  assign wr_data_phase = cmd_reg.valid && cmd_reg.write;

  // ---------------------------------------------------------------
  // per-entry decode, write strobes and storage
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < REG_COUNT; i = i + 1) begin : g_entry
      // full address compare, so neighbouring registers never alias
      assign addr_hit[i] = (haddr == REG_ADDR[i]);
      assign data_hit[i] = (cmd_reg.addr == REG_ADDR[i]);

      // a write to the periodic pointer is accepted on the bus and dropped
      if (i == IDX_PERIODIC) begin : g_read_only
        assign sw_we[i] = 1'h0;
      end else begin : g_writable
        assign sw_we[i] = wr_data_phase && data_hit[i];
      end

      ulpr_ptr_reg #(
        .LOW_BITS (REG_LOW_BITS[i])
      ) u_ptr (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .sw_we      (sw_we[i]),
        .sw_wdata   (hwdata),
        .hw_we      (hw_we[i]),
        .hw_wdata   (hw_wdata[i]),
        .value      (reg_value[i]),
        .value_next (reg_value_next[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read index
  // ---------------------------------------------------------------
  // at most one entry hits, so the last hit is the only hit
  always_comb begin
    addr_known = 1'h0;
    addr_idx   = '0;
    for (int n = 0; n < REG_COUNT; n++) begin
      if (addr_hit[n]) begin
        addr_known = 1'h1;
        addr_idx   = IDX_W'(n);
      end
    end
  end

  // ---------------------------------------------------------------
  // list engine requests
  // ---------------------------------------------------------------
  // the engine only reads the base; the init load of the head is the
  // engine fetching it from the shared area and beats a same-cycle
  // software write
  always_comb begin
    hw_we                  = '0;
    hw_wdata[IDX_COMM]     = ulpr_pkg::POINTER_RESET;
    hw_wdata[IDX_PERIODIC] = engine_req.periodic_value;
    hw_wdata[IDX_HEAD]     = engine_req.head_init_value;
    hw_we[IDX_PERIODIC]    = engine_req.periodic_update;
    hw_we[IDX_HEAD]        = engine_req.head_init_load;
  end

  // ---------------------------------------------------------------
  // bus next state
  // ---------------------------------------------------------------
  // read data is taken from the next values so a read right behind
  // a write already returns the written word
  always_comb begin
    cmd_next       = cmd_reg;
    hrdata_next    = hrdata_reg;
    hreadyout_next = hreadyout_reg;
    hresp_next     = hresp_reg;
    if (clk_en) begin
      hreadyout_next = ulpr_pkg::HREADY_DONE;
      hresp_next     = ulpr_pkg::HRESP_OKAY;
      if (hready) begin
        cmd_next.valid = addr_phase;
        cmd_next.write = hwrite;
        cmd_next.addr  = haddr;
      end
      if (rd_addr_phase) begin
        if (addr_known) begin
          hrdata_next = reg_value_next[addr_idx];
        end else begin
          hrdata_next = ulpr_pkg::UNMAPPED_READ;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_reg       <= '0;
      hrdata_reg    <= ulpr_pkg::UNMAPPED_READ;
      hreadyout_reg <= ulpr_pkg::HREADY_DONE;
      hresp_reg     <= ulpr_pkg::HRESP_OKAY;
    end else begin
      cmd_reg       <= cmd_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg     <= hresp_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  // the engine walks the shared area and lists from these
  assign pointers.comm_area_base_field     = reg_value[IDX_COMM];
  assign pointers.periodic_current_pointer = reg_value[IDX_PERIODIC];
  assign pointers.control_head_pointer     = reg_value[IDX_HEAD];

endmodule

// ===== rtl/ulpr_pkg.sv
// Purpose : shared constants and carriers for the list pointer register bank
// Assumes : AHB-Lite slave, 32-bit single word transfers only
// Notes   : byte addresses are the full system addresses of the registers
package ulpr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_COMM_AREA_BASE    = 32'hE000_7018;
  localparam logic [31:0] ADDR_PERIODIC_CURRENT  = 32'hE000_701C;
  localparam logic [31:0] ADDR_CONTROL_LIST_HEAD = 32'hE000_7020;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          COMM_AREA_LOW_BITS  = 8;
  localparam int          DESCRIPTOR_LOW_BITS = 4;
  localparam logic [31:0] POINTER_RESET       = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;

  // ---------------------------------------------------------------
  // bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic        HREADY_DONE   = 1'h1;

  // ---------------------------------------------------------------
  // carriers between the bank and the list engine
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        periodic_update;
    logic [31:0] periodic_value;
    logic        head_init_load;
    logic [31:0] head_init_value;
  } ulpr_engine_req_t;

  typedef struct packed {
    logic [31:0] comm_area_base_field;
    logic [31:0] periodic_current_pointer;
    logic [31:0] control_head_pointer;
  } ulpr_pointers_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } ulpr_bus_cmd_t;

endpackage

// ===== rtl/ulpr_ptr_reg.sv
// Purpose : one pointer register with forced-zero low bits
// Assumes : software and list engine writes arrive on the same clock
// Notes   : engine write wins over software write in the same cycle
`timescale 1ns/1ps

module ulpr_ptr_reg #(
  parameter int LOW_BITS = 4
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // software side
  input  wire logic        sw_we,
  input  wire logic [31:0] sw_wdata,
  // list engine side
  input  wire logic        hw_we,
  input  wire logic [31:0] hw_wdata,
  // stored value and the value it takes at the next edge
  output logic      [31:0] value,
  output logic      [31:0] value_next
);

  logic [31:0] value_reg;
  logic [31:0] keep_mask;

  // ---------------------------------------------------------------
  // per-bit mask: low bits never store anything
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_mask
      assign keep_mask[b] = (b >= LOW_BITS);
    end
  endgenerate

  // ---------------------------------------------------------------
  // next value
  // ---------------------------------------------------------------
  always_comb begin
    value_next = value_reg;
    if (clk_en) begin
      if (hw_we) begin
        value_next = hw_wdata & keep_mask;
      end else if (sw_we) begin
        value_next = sw_wdata & keep_mask;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= ulpr_pkg::POINTER_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule
